// *** rtl/cxd_regs.vh ***
// Register offsets, fields and opcode patterns of the cxd decoder
`ifndef CXD_REGS_VH
`define CXD_REGS_VH
`define CXD_A_CTRL 8'h00
`define CXD_A_WORD0 8'h04
`define CXD_A_WORD1 8'h08
`define CXD_A_WORK 8'h0c
`define CXD_A_BANK 8'h10
`define CXD_A_FSR0 8'h14
`define CXD_A_FSR1 8'h18
`define CXD_A_STACK_FRAME_POINTER 8'h1c
`define CXD_A_FLAGS 8'h20
`define CXD_A_EXEC 8'h24
`define CXD_A_PCLATH 8'h28
`define CXD_A_DADDR 8'h2c
`define CXD_A_DDATA 8'h30
`define CXD_A_CALLT 8'h34
`define CXD_CTRL_GO 0
`define CXD_CTRL_EXT 1
`define CXD_EXT_RST 1'b1
`define CXD_FL_Z 2
`define CXD_FL_N 4
`define CXD_EX_BUSY 0
`define CXD_EX_SKIP 1
`define CXD_EX_RET 2
`define CXD_EX_CALL 3
`define CXD_EX_CYC 4
`define CXD_EX_WORDS 6
`define CXD_RESP_OK 2'b00
`define CXD_RESP_ERR 2'b10
`define CXD_Q2 2'd1
`define CXD_Q3 2'd2
`define CXD_Q4 2'd3
`define CXD_ACC_LIMIT 8'h5f
`define CXD_ACC_LO 4'h0
`define CXD_ACC_HI 4'hf
`define CXD_PAT_TST 7'b0110011
`define CXD_PAT_XOR_LITERAL_INTO_WORK 8'h0a
`define CXD_PAT_XOR_WORK_WITH_FILE 6'b000110
`define CXD_PAT_ADDF 8'he8
`define CXD_PAT_SUBF 8'he9
`define CXD_PAT_PUSH_LITERAL_FRAME 8'hea
`define CXD_PAT_MOVS 8'heb
`define CXD_PAT_CALL_VIA_WORK_REGISTER 16'h0014
`define CXD_PAT_SECOND 4'hf
`define CXD_PAT_MOVFF 4'hc
`define CXD_PAT_CALL 7'b1110110
`define CXD_PAT_GOTO 8'hef
`define CXD_PAT_LFSR 8'hee
`define CXD_FSR_FRAME 2'b11
`endif

// *** rtl/cxd_phase.v ***
// Four-phase divider giving the Q1..Q4 position inside an instruction cycle
`timescale 1ns/1ps
module cxd_phase (
  input wire mclk,
  input wire sys_rst,
  input wire restart,
  output reg [1:0] phase_reg
);
  always @(posedge mclk) begin
    if (sys_rst || restart) begin
      phase_reg <= 2'd0;
    end else begin
      phase_reg <= phase_reg + 2'd1;
    end
  end
endmodule // cxd_phase

// *** rtl/cxd_mem.v ***
// Data memory of 4096 bytes with registered read data
`timescale 1ns/1ps
module cxd_mem (
  input wire mclk,
  input wire [11:0] addr,
  input wire we,
  input wire [7:0] wdata,
  output reg [7:0] rdata_reg
);
  reg [7:0] mem [0:4095];
  always @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata_reg <= mem[addr];
  end
endmodule // cxd_mem

// *** rtl/cxd_core.v ***
// Decoder and executor for test-skip, exclusive-OR and extended group opcodes
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module cxd_core (
  input wire mclk,
  input wire sys_rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
`include "cxd_regs.vh"
  localparam OP_NOP = 4'd0;
  localparam OP_TST = 4'd1;
  localparam OP_XOR_LITERAL_INTO_WORK = 4'd2;
  localparam OP_XOR_WORK_WITH_FILE = 4'd3;
  localparam OP_ADDF = 4'd4;
  localparam OP_SUBF = 4'd5;
  localparam OP_ADDU = 4'd6;
  localparam OP_SUBU = 4'd7;
  localparam OP_CALL_VIA_WORK_REGISTER = 4'd8;
  localparam OP_MOVE_INDEXED_TO_ABSOLUTE = 4'd9;
  localparam OP_MOVE_INDEXED_TO_INDEXED = 4'd10;
  localparam OP_PUSH_LITERAL_FRAME = 4'd11;

  reg [15:0] word0_reg, word1_reg, callt_reg;
  reg [7:0] w_reg, bsr_reg, pclath_reg, hold_reg, xres_reg;
  reg [11:0] fsr0_reg, fsr1_reg, stack_frame_pointer_reg, daddr_reg;
  reg ext_reg, busy_reg, skip_reg, ret_reg, call_reg, n_reg, z_reg;
  reg [1:0] cyc_reg, ncyc_reg, words_reg;
  reg aw_have_reg, w_have_reg;
  reg [7:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg [31:0] rd_val;
  reg rd_ok;
  reg [11:0] eng_addr;
  reg [11:0] ptr_sel;
  wire [1:0] phase;
  wire [7:0] mem_rdata;

  // Opcode classification, extended group only while enabled
  function [3:0] decode_op;
    input [15:0] w;
    input ext;
    begin
      decode_op = OP_NOP;
      if (w[15:9] == `CXD_PAT_TST) begin
        decode_op = OP_TST;
      end else if (w[15:8] == `CXD_PAT_XOR_LITERAL_INTO_WORK) begin
        decode_op = OP_XOR_LITERAL_INTO_WORK;
      end else if (w[15:10] == `CXD_PAT_XOR_WORK_WITH_FILE) begin
        decode_op = OP_XOR_WORK_WITH_FILE;
      end else if (ext) begin
        if (w == `CXD_PAT_CALL_VIA_WORK_REGISTER) begin
          decode_op = OP_CALL_VIA_WORK_REGISTER;
        end else if (w[15:8] == `CXD_PAT_ADDF) begin
          decode_op = (w[7:6] == `CXD_FSR_FRAME) ? OP_ADDU : OP_ADDF;
        end else if (w[15:8] == `CXD_PAT_SUBF) begin
          decode_op = (w[7:6] == `CXD_FSR_FRAME) ? OP_SUBU : OP_SUBF;
        end else if (w[15:8] == `CXD_PAT_MOVS) begin
          decode_op = w[7] ? OP_MOVE_INDEXED_TO_INDEXED : OP_MOVE_INDEXED_TO_ABSOLUTE;
        end else if (w[15:8] == `CXD_PAT_PUSH_LITERAL_FRAME) begin
          decode_op = OP_PUSH_LITERAL_FRAME;
        end
      end
    end
  endfunction

  // First word of a two-word instruction
  function two_word;
    input [15:0] w;
    input ext;
    begin
      two_word = (w[15:12] == `CXD_PAT_MOVFF) || (w[15:9] == `CXD_PAT_CALL) ||
        (w[15:8] == `CXD_PAT_GOTO) || (w[15:8] == `CXD_PAT_LFSR) ||
        (ext && w[15:8] == `CXD_PAT_MOVS);
    end
  endfunction

  // Byte-oriented operand address
  function [11:0] file_addr;
    input [7:0] f;
    input a;
    input [7:0] bank_selection_register;
    input ext;
    input [11:0] fp;
    begin
      if (a) begin
        file_addr = {bank_selection_register[3:0], f};
      end else if (f <= `CXD_ACC_LIMIT) begin
        file_addr = ext ? fp + {4'h0, f} : {`CXD_ACC_LO, f};
      end else begin
        file_addr = {`CXD_ACC_HI, f};
      end
    end
  endfunction

  // Byte-lane merge for the low half of a register
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] d;
    input [3:0] s;
    begin
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  wire [3:0] op = decode_op(word0_reg, ext_reg);
  wire is_movs = (op == OP_MOVE_INDEXED_TO_ABSOLUTE) || (op == OP_MOVE_INDEXED_TO_INDEXED);
  wire q3 = busy_reg && (phase == `CXD_Q3);
  wire q4 = busy_reg && (phase == `CXD_Q4);
  wire cyc0 = (cyc_reg == 2'd0);
  wire [11:0] fa = file_addr(word0_reg[7:0], word0_reg[8], bsr_reg, ext_reg, stack_frame_pointer_reg);
  wire [11:0] src_ind = stack_frame_pointer_reg + {5'd0, word0_reg[6:0]};
  wire [11:0] dst_ind = stack_frame_pointer_reg + {5'd0, word1_reg[6:0]};
  wire [11:0] dst_addr = (op == OP_MOVE_INDEXED_TO_INDEXED) ? dst_ind : word1_reg[11:0];
  wire [11:0] kext = {6'd0, word0_reg[5:0]};
  wire wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
  wire wr_hit = wr_fire && !busy_reg;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire dd_wr = wr_hit && (awaddr_reg == `CXD_A_DDATA) && wstrb_reg[0];
  wire [15:0] m0 = merge16({word0_reg}, wdata_reg, wstrb_reg);
  wire [15:0] m1 = merge16({word1_reg}, wdata_reg, wstrb_reg);
  wire eng_we = q4 && (((op == OP_XOR_WORK_WITH_FILE) && word0_reg[9] && cyc0) ||
    ((op == OP_PUSH_LITERAL_FRAME) && cyc0) || (is_movs && !cyc0));
  wire [7:0] eng_wd = (op == OP_PUSH_LITERAL_FRAME) ? word0_reg[7:0] : (is_movs ? hold_reg : xres_reg);
  wire [11:0] mem_addr = busy_reg ? eng_addr : daddr_reg;
  wire go = wr_hit && (awaddr_reg == `CXD_A_CTRL) && wstrb_reg[0] &&
    wdata_reg[`CXD_CTRL_GO];
  // Cycle count at start uses the enable bit written with the start pulse
  wire [3:0] go_op = decode_op(word0_reg, wdata_reg[`CXD_CTRL_EXT]);
  wire go_movs = (go_op == OP_MOVE_INDEXED_TO_ABSOLUTE) || (go_op == OP_MOVE_INDEXED_TO_INDEXED);
  wire [15:0] mf0 = merge16({4'h0, fsr0_reg}, wdata_reg, wstrb_reg);
  wire [15:0] mf1 = merge16({4'h0, fsr1_reg}, wdata_reg, wstrb_reg);
  wire [15:0] mf2 = merge16({4'h0, stack_frame_pointer_reg}, wdata_reg, wstrb_reg);
  wire [15:0] mfd = merge16({4'h0, daddr_reg}, wdata_reg, wstrb_reg);

  assign s_axi_awready = !aw_have_reg;
  assign s_axi_wready = !w_have_reg;
  assign s_axi_arready = !s_axi_rvalid;

  // Engine memory address per opcode and cycle
  always @* begin
    eng_addr = fa;
    if (op == OP_PUSH_LITERAL_FRAME) begin
      eng_addr = stack_frame_pointer_reg;
    end else if (is_movs) begin
      eng_addr = cyc0 ? src_ind : dst_addr;
    end
  end

  // Pointer picked by the two-bit field
  always @* begin
    case (word0_reg[7:6])
      2'd0: ptr_sel = fsr0_reg;
      2'd1: ptr_sel = fsr1_reg;
      default: ptr_sel = stack_frame_pointer_reg;
    endcase
  end

  // Register read mux
  always @* begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `CXD_A_CTRL: rd_val[`CXD_CTRL_EXT] = ext_reg;
      `CXD_A_WORD0: rd_val[15:0] = word0_reg;
      `CXD_A_WORD1: rd_val[15:0] = word1_reg;
      `CXD_A_WORK: rd_val[7:0] = w_reg;
      `CXD_A_BANK: rd_val[7:0] = bsr_reg;
      `CXD_A_FSR0: rd_val[11:0] = fsr0_reg;
      `CXD_A_FSR1: rd_val[11:0] = fsr1_reg;
      `CXD_A_STACK_FRAME_POINTER: rd_val[11:0] = stack_frame_pointer_reg;
      `CXD_A_FLAGS: begin
        rd_val[`CXD_FL_Z] = z_reg;
        rd_val[`CXD_FL_N] = n_reg;
      end
      `CXD_A_EXEC: begin
        rd_val[`CXD_EX_BUSY] = busy_reg;
        rd_val[`CXD_EX_SKIP] = skip_reg;
        rd_val[`CXD_EX_RET] = ret_reg;
        rd_val[`CXD_EX_CALL] = call_reg;
        rd_val[`CXD_EX_CYC+1:`CXD_EX_CYC] = ncyc_reg + 2'd1;
        rd_val[`CXD_EX_WORDS+1:`CXD_EX_WORDS] = words_reg;
      end
      `CXD_A_PCLATH: rd_val[7:0] = pclath_reg;
      `CXD_A_DADDR: rd_val[11:0] = daddr_reg;
      `CXD_A_DDATA: rd_val[7:0] = busy_reg ? 8'h00 : mem_rdata;
      `CXD_A_CALLT: rd_val[15:0] = callt_reg;
      default: rd_ok = 1'b0;
    endcase
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      word0_reg <= 16'h0000;
      word1_reg <= 16'h0000;
      callt_reg <= 16'h0000;
      w_reg <= 8'h00;
      bsr_reg <= 8'h00;
      pclath_reg <= 8'h00;
      hold_reg <= 8'h00;
      xres_reg <= 8'h00;
      fsr0_reg <= 12'h000;
      fsr1_reg <= 12'h000;
      stack_frame_pointer_reg <= 12'h000;
      daddr_reg <= 12'h000;
      ext_reg <= `CXD_EXT_RST;
      busy_reg <= 1'b0;
      skip_reg <= 1'b0;
      ret_reg <= 1'b0;
      call_reg <= 1'b0;
      n_reg <= 1'b0;
      z_reg <= 1'b0;
      cyc_reg <= 2'd0;
      ncyc_reg <= 2'd0;
      words_reg <= 2'd0;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CXD_RESP_OK;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CXD_RESP_OK;
    end else begin
      if (s_axi_awvalid && !aw_have_reg) begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_reg) begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (ar_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? `CXD_RESP_OK : `CXD_RESP_ERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `CXD_RESP_OK;
        case (awaddr_reg)
          `CXD_A_CTRL, `CXD_A_FLAGS, `CXD_A_EXEC, `CXD_A_DDATA, `CXD_A_CALLT: ;
          `CXD_A_WORD0, `CXD_A_WORD1, `CXD_A_WORK, `CXD_A_BANK, `CXD_A_PCLATH: ;
          `CXD_A_FSR0, `CXD_A_FSR1, `CXD_A_STACK_FRAME_POINTER, `CXD_A_DADDR: ;
          default: s_axi_bresp <= `CXD_RESP_ERR;
        endcase
      end
      // Software writes are ignored while an instruction runs
      if (wr_hit) begin
        case (awaddr_reg)
          `CXD_A_CTRL: if (wstrb_reg[0]) ext_reg <= wdata_reg[`CXD_CTRL_EXT];
          `CXD_A_WORD0: word0_reg <= m0;
          `CXD_A_WORD1: word1_reg <= m1;
          `CXD_A_WORK: if (wstrb_reg[0]) w_reg <= wdata_reg[7:0];
          `CXD_A_BANK: if (wstrb_reg[0]) bsr_reg <= wdata_reg[7:0];
          `CXD_A_PCLATH: if (wstrb_reg[0]) pclath_reg <= wdata_reg[7:0];
          `CXD_A_FSR0: fsr0_reg <= mf0[11:0];
          `CXD_A_FSR1: fsr1_reg <= mf1[11:0];
          `CXD_A_STACK_FRAME_POINTER: stack_frame_pointer_reg <= mf2[11:0];
          `CXD_A_DADDR: daddr_reg <= mfd[11:0];
          default: ;
        endcase
      end
      if (go) begin
        busy_reg <= 1'b1;
        cyc_reg <= 2'd0;
        skip_reg <= 1'b0;
        ret_reg <= 1'b0;
        call_reg <= 1'b0;
        ncyc_reg <= (go_op == OP_ADDU || go_op == OP_SUBU || go_op == OP_CALL_VIA_WORK_REGISTER || go_movs) ?
          2'd1 : 2'd0;
        words_reg <= go_movs ? 2'd2 : 2'd1;
      end
      if (q3 && cyc0) begin
        xres_reg <= w_reg ^ ((op == OP_XOR_LITERAL_INTO_WORK) ? word0_reg[7:0] : mem_rdata);
        hold_reg <= mem_rdata;
        if (op == OP_TST && mem_rdata == 8'h00) begin
          skip_reg <= 1'b1;
          ncyc_reg <= two_word(word1_reg, ext_reg) ? 2'd2 : 2'd1;
          words_reg <= two_word(word1_reg, ext_reg) ? 2'd3 : 2'd2;
        end
      end
      if (q4) begin
        if (cyc0) begin
          case (op)
            OP_XOR_LITERAL_INTO_WORK, OP_XOR_WORK_WITH_FILE: begin
              n_reg <= xres_reg[7];
              z_reg <= (xres_reg == 8'h00);
              if (op == OP_XOR_LITERAL_INTO_WORK || !word0_reg[9]) begin
                w_reg <= xres_reg;
              end
            end
            OP_ADDF, OP_ADDU, OP_SUBF, OP_SUBU: begin
              case ((op == OP_ADDU || op == OP_SUBU) ? `CXD_FSR_FRAME : word0_reg[7:6])
                2'd0: fsr0_reg <= (op == OP_ADDF) ? fsr0_reg + kext : fsr0_reg - kext;
                2'd1: fsr1_reg <= (op == OP_ADDF) ? fsr1_reg + kext : fsr1_reg - kext;
                default: stack_frame_pointer_reg <= (op == OP_ADDF || op == OP_ADDU) ?
                  ptr_sel + kext : ptr_sel - kext;
              endcase
              ret_reg <= (op == OP_ADDU || op == OP_SUBU);
            end
            OP_CALL_VIA_WORK_REGISTER: begin
              call_reg <= 1'b1;
              callt_reg <= {pclath_reg, w_reg};
            end
            OP_PUSH_LITERAL_FRAME: stack_frame_pointer_reg <= stack_frame_pointer_reg - 12'h001;
            default: ;
          endcase
        end
        if (cyc_reg == ncyc_reg) begin
          busy_reg <= 1'b0;
        end else begin
          cyc_reg <= cyc_reg + 2'd1;
        end
      end
      if (dd_wr) begin
        daddr_reg <= daddr_reg;
      end
    end
  end

  cxd_phase u_phase (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .restart(go),
    .phase_reg(phase)
  );

  cxd_mem u_mem (
    .mclk(mclk),
    .addr(mem_addr),
    .we(busy_reg ? eng_we : dd_wr),
    .wdata(busy_reg ? eng_wd : wdata_reg[7:0]),
    .rdata_reg(mem_rdata)
  );
endmodule // cxd_core

// *** dv/cxd_core_chk.sv ***
// Bus handshake checker for the cxd decoder
`timescale 1ns/1ps
module cxd_core_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  AST_RST_IDLE: assert property (disable iff (1'b0) sys_rst |=>
    !s_axi_bvalid && !s_axi_rvalid && s_axi_awready && s_axi_wready)
    else $error("bus not idle after reset");
  AST_B_LAT: assert property (both_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_B_HOLD: assert property (b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_AW_HELD: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address accepted twice");
  AST_AR_RDY: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready not inverse of rvalid");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data changed");
  AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
endmodule // cxd_core_chk

bind cxd_core cxd_core_chk cxd_core_chk_i (.mclk(mclk), .sys_rst(sys_rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// *** dv/cpu_xor_test_and_stack_ext_decoder_tb.sv ***
// Self-checking bench for the cxd decoder through its register bus
`timescale 1ns/1ps
`include "cxd_regs.vh"
module cpu_xor_test_and_stack_ext_decoder_tb;
  logic mclk, sys_rst;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, lr;
  logic ext;
  integer bad_count, tests_run;
  cxd_core cxd_core_i (.mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task bw(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= d; s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    lr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task br(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata; lr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e, input string n);
    br(a);
    chk(n, e, v);
  endtask
  task mw(input logic [11:0] a, input logic [7:0] d);
    bw(`CXD_A_DADDR, {20'h0, a}); bw(`CXD_A_DDATA, {24'h0, d});
  endtask
  task mchk(input logic [11:0] a, input logic [7:0] e);
    bw(`CXD_A_DADDR, {20'h0, a}); rchk(`CXD_A_DDATA, {24'h0, e}, "memory byte");
  endtask
  task run(input logic [15:0] w0, input logic [15:0] w1, input logic [1:0] cyc);
    integer n;
    bw(`CXD_A_WORD0, {16'h0, w0}); bw(`CXD_A_WORD1, {16'h0, w1});
    bw(`CXD_A_CTRL, {30'h0, ext, 1'b1});
    n = 0;
    do begin
      br(`CXD_A_EXEC);
      n++;
    end while (v[0] !== 1'b0 && n < 50);
    chk("busy cleared", 32'h0, {31'h0, v[0]});
    chk("cycles taken", {30'h0, cyc}, {30'h0, v[5:4]});
  endtask
  task t_reset;
    rchk(`CXD_A_CTRL, 32'h2, "control after reset");
    br(8'h3c);
    chk("unmapped response", {30'h0, `CXD_RESP_ERR}, {30'h0, lr});
    $display("reset test done");
  endtask
  task t_xor;
    bw(`CXD_A_WORK, 32'hb5); run(16'h0aaf, 16'h0, 2'd1);
    rchk(`CXD_A_WORK, 32'h1a, "literal xor");
    rchk(`CXD_A_FLAGS, 32'h0, "flags clear");
    run(16'h0a1a, 16'h0, 2'd1); rchk(`CXD_A_FLAGS, 32'h4, "zero flag");
    bw(`CXD_A_WORK, 32'hb5); bw(`CXD_A_BANK, 32'h2); mw(12'h240, 8'haf);
    run(16'h1b40, 16'h0, 2'd1);
    mchk(12'h240, 8'h1a);
    rchk(`CXD_A_WORK, 32'hb5, "work kept");
    mw(12'hf80, 8'h35); run(16'h1880, 16'h0, 2'd1);
    rchk(`CXD_A_WORK, 32'h80, "work result");
    rchk(`CXD_A_FLAGS, 32'h10, "negative flag");
    $display("xor test done");
  endtask
  task t_skip;
    mw(12'h240, 8'h01);
    run(16'h6740, 16'h0, 2'd1);
    chk("no skip", 32'h0, {31'h0, v[1]});
    mw(12'h240, 8'h00); run(16'h6740, 16'h0, 2'd2);
    chk("skip", 32'h1, {31'h0, v[1]});
    run(16'h6740, 16'hef00, 2'd3);
    chk("skip words", 32'h3, {30'h0, v[7:6]});
    rchk(`CXD_A_FLAGS, 32'h10, "flags untouched");
    bw(`CXD_A_STACK_FRAME_POINTER, 32'h300); mw(12'h310, 8'h00); mw(12'h010, 8'h05);
    run(16'h6610, 16'h0, 2'd2);
    ext = 1'b0;
    run(16'h6610, 16'h0, 2'd1);
    ext = 1'b1;
    $display("skip test done");
  endtask
  task t_ext;
    bw(`CXD_A_FSR1, 32'h3ff); run(16'he863, 16'h0, 2'd1);
    rchk(`CXD_A_FSR1, 32'h422, "pointer add");
    bw(`CXD_A_STACK_FRAME_POINTER, 32'h3ff); run(16'he8e3, 16'h0, 2'd2);
    chk("return flag", 32'h1, {31'h0, v[2]});
    rchk(`CXD_A_STACK_FRAME_POINTER, 32'h422, "frame add");
    bw(`CXD_A_STACK_FRAME_POINTER, 32'h200); run(16'hea55, 16'h0, 2'd1);
    rchk(`CXD_A_STACK_FRAME_POINTER, 32'h1ff, "frame decrement");
    mchk(12'h200, 8'h55);
    bw(`CXD_A_WORK, 32'h34); bw(`CXD_A_PCLATH, 32'h12); run(16'h0014, 16'h0, 2'd2);
    chk("call flag", 32'h1, {31'h0, v[3]});
    rchk(`CXD_A_CALLT, 32'h1234, "call target");
    bw(`CXD_A_STACK_FRAME_POINTER, 32'h100); mw(12'h105, 8'h77); run(16'heb05, 16'hf123, 2'd2);
    chk("move words", 32'h2, {30'h0, v[7:6]});
    mchk(12'h123, 8'h77);
    run(16'hf000, 16'h0, 2'd1);
    chk("lone word", 32'h1, {30'h0, v[7:6]});
    ext = 1'b0;
    bw(`CXD_A_FSR1, 32'h10); run(16'he863, 16'h0, 2'd1);
    rchk(`CXD_A_FSR1, 32'h10, "pointer kept");
    ext = 1'b1;
    $display("extended test done");
  endtask
  initial begin
    #1000000;
    bad_count++;
    complete_run;
  end
  initial begin
    bad_count = 0; tests_run = 0; ext = 1'b1; sys_rst = 1'b1;
    s_axi_awaddr = 8'h00; s_axi_awvalid = 1'b0; s_axi_wdata = 32'h0; s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_araddr = 8'h00; s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset;
    t_xor;
    t_skip;
    t_ext;
    complete_run;
  end
endmodule // cpu_xor_test_and_stack_ext_decoder_tb
